// ==== src/lbs_pkg.sv ====
// Purpose: shared constants, register map and carriers of the logic tile
// Assumes: APB register bus, 32-bit data, byte addresses
// Notes:   configuration is software-written; the tile data path faces user logic
package lbs_pkg;

    localparam int NUM_CELLS  = 4;
    localparam int NUM_SLICES = 2;
    localparam int LUT_INPUTS = 4;
    localparam int LUT_DEPTH  = 16;
    localparam int ADDR_W     = 8;
    localparam int CFG_W      = 15;
    localparam int STATUS_W   = 6;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_TRUTH0 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CFG0   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CFG1   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;

    typedef enum logic [2:0] {
        LBS_FUNC    = 3'h0,
        LBS_RAM16X1 = 3'h1,
        LBS_RAM16X2 = 3'h2,
        LBS_RAM32X1 = 3'h3,
        LBS_DPRAM   = 3'h4,
        LBS_SHIFT   = 3'h5
    } lbs_mode_e;

    // per-slice configuration word, mode in the low bits
    typedef struct packed {
        logic [1:0] andGen;
        logic       invOpp;
        logic       invInit;
        logic       invCe;
        logic       invClk;
        logic       forceAsync;
        logic [1:0] directSel;
        logic [1:0] initVal;
        logic       latchMode;
        lbs_mode_e  mode;
    } lbs_slice_cfg_s;

    localparam lbs_slice_cfg_s CFG_RESET   = '0;
    localparam logic [LUT_DEPTH-1:0] TRUTH_RESET = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } lbs_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lbs_apb_rsp_s;

    typedef struct packed {
        logic [NUM_CELLS-1:0][LUT_INPUTS-1:0] lutIn;
        logic [NUM_CELLS-1:0]                 directIn;
        logic [NUM_CELLS-1:0]                 feedIn;
        logic [NUM_SLICES-1:0]                carryIn;
        logic [NUM_SLICES-1:0]                fiveMuxSel;
        logic                                 sixMuxSel;
        logic [NUM_SLICES-1:0]                sliceClk;
        logic [NUM_SLICES-1:0]                sliceCe;
        logic [NUM_SLICES-1:0]                initStateForce;
        logic [NUM_SLICES-1:0]                oppositeStateForce;
        logic [NUM_SLICES-1:0]                ramWe;
        logic [NUM_SLICES-1:0][1:0]           ramWd;
        logic [1:0]                           busDrvData;
        logic [1:0]                           busDrvEn_n;
    } lbs_tile_in_s;

    typedef struct packed {
        logic [NUM_CELLS-1:0]  lutOut;
        logic [NUM_CELLS-1:0]  regOut;
        logic [NUM_CELLS-1:0]  sumOut;
        logic [NUM_SLICES-1:0] carryOut;
        logic [NUM_SLICES-1:0] fiveMux;
        logic                  sixMux;
        logic [NUM_CELLS-1:0]  feedOut;
        logic [1:0]            busDrvOut;
        logic [1:0]            busDrvOe_n;
        logic                  busNet;
    } lbs_tile_out_s;

endpackage : lbs_pkg

// ==== src/lbs_logic_cell.sv ====
// Purpose: one logic cell: 4-input table lookup plus carry and sum gates
// Assumes: truth contents held by the tile
// Notes:   purely combinational, the tile owns all state
`timescale 1ns/100ps
`default_nettype none
module lbs_logic_cell #(
    parameter int INPUTS = 4
) (
    input  wire logic [(1<<INPUTS)-1:0] truth,
    input  wire logic [INPUTS-1:0]      addr,
    input  wire logic [INPUTS-1:0]      andIn,
    input  wire logic                   carryIn,
    input  wire logic                   genDirect,
    input  wire logic                   genAndSel,
    output var  logic                   lutOut,
    output var  logic                   sumOut,
    output var  logic                   carryOut
);
    logic genBit;

    always_comb begin
        lutOut   = truth[addr];                              // [RL1]
        // and gate forms a partial product as carry generate
        genBit   = genAndSel ? (andIn[0] & andIn[1]) : genDirect; // [RL16]
        sumOut   = lutOut ^ carryIn;                         // [RL16]
        carryOut = lutOut ? carryIn : genBit;                // [RL15]
    end
endmodule : lbs_logic_cell
`default_nettype wire

// ==== src/lbs_logic_tile.sv ====
// Purpose: logic tile of four cells in two slices with APB configuration
// Assumes: user-side inputs come from logic on the same clock
// Notes:   slice clock is a sampled level, its active edge seen one cycle late
//
// Summary of operation
// RL1: each table computes any four-input function
// RL2: table output to tile output or storage
// RL3: each table usable as 16x1 memory
// RL4: slice tables combine into wider or dual-port memory
// RL5: each table usable as 16-bit shift register
// RL6: writes only on active edge with enable
// RL7: storage is flip-flop or level latch
// RL8: storage input from table or direct input
// RL9: init force loads configured init value
// RL10: opposite force loads complement of init
// RL11: forces synchronous, optionally asynchronous
// RL12: controls invertible and shared per slice
// RL13: five-input combiner selects between slice tables
// RL14: six-input combiner selects between slice combiners
// RL15: one carry chain per slice, two bits
// RL16: per-cell xor for sum, and gate
// RL17: bus driver drives while enable low
// RL18: undriven bus net resolves high
// RL19: conflicting drivers resolve low, no contention
// RL20: four direct feedthrough paths
`timescale 1ns/100ps
`default_nettype none
module lbs_logic_tile #(
    parameter int EXT_DRIVERS = 2
) (
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    input  wire logic                    clkEn,
    input  wire lbs_pkg::lbs_apb_req_s   apbReq,
    output var  lbs_pkg::lbs_apb_rsp_s   apbRsp,
    input  wire lbs_pkg::lbs_tile_in_s   tileIn,
    input  wire logic [EXT_DRIVERS-1:0]  extDrvData,
    input  wire logic [EXT_DRIVERS-1:0]  extDrvEn_n,
    output var  lbs_pkg::lbs_tile_out_s  tileOut
);
    typedef struct packed {
        logic [lbs_pkg::NUM_CELLS-1:0][lbs_pkg::LUT_DEPTH-1:0] truth;
        lbs_pkg::lbs_slice_cfg_s [lbs_pkg::NUM_SLICES-1:0]     cfg;
        logic [lbs_pkg::NUM_CELLS-1:0]                         stored;
        logic [lbs_pkg::NUM_SLICES-1:0]                        clkPrev;
        logic [31:0]                                           rdata;
    } lbs_tile_state_s;

    lbs_tile_state_s st_q;
    lbs_tile_state_s st_d;

    logic [lbs_pkg::NUM_CELLS-1:0][lbs_pkg::LUT_INPUTS-1:0] rdAddr;
    logic [lbs_pkg::NUM_CELLS-1:0]                          lutOut;
    logic [lbs_pkg::NUM_CELLS-1:0]                          sumOut;
    logic [lbs_pkg::NUM_CELLS-1:0]                          cellCin;
    logic [lbs_pkg::NUM_CELLS-1:0]                          cellCout;
    logic [lbs_pkg::NUM_CELLS-1:0]                          cellD;
    logic [lbs_pkg::NUM_CELLS-1:0]                          regOut;
    logic [lbs_pkg::NUM_SLICES-1:0]                         fiveMux;
    logic                                                   sixMux;
    logic                                                   apbSetup;
    logic                                                   apbWrite;
    logic                                                   apbMapped;
    logic [31:0]                                            readWord;
    logic                                                   busNet;

    genvar gc;
    generate
        for (gc = 0; gc < lbs_pkg::NUM_CELLS; gc++) begin : g_cell
            localparam int SL  = gc / 2;
            localparam int ODD = gc % 2;
            lbs_pkg::lbs_mode_e cellMode;
            assign cellMode = st_q.cfg[SL].mode;
            // wide and 2-bit memories read both tables at the first address
            if (ODD == 1) begin : g_odd
                assign rdAddr[gc]  = (cellMode == lbs_pkg::LBS_RAM16X2 || cellMode == lbs_pkg::LBS_RAM32X1)
                                     ? tileIn.lutIn[gc-1] : tileIn.lutIn[gc]; // [RL4]
                assign cellCin[gc] = cellCout[gc-1];                          // [RL15]
            end else begin : g_even
                assign rdAddr[gc]  = tileIn.lutIn[gc];
                assign cellCin[gc] = tileIn.carryIn[SL];                      // [RL15]
            end
            lbs_logic_cell #(
                .INPUTS (lbs_pkg::LUT_INPUTS)
            ) u_cell (
                .truth     (st_q.truth[gc]),
                .addr      (rdAddr[gc]),
                .andIn     (tileIn.lutIn[gc]),
                .carryIn   (cellCin[gc]),
                .genDirect (tileIn.directIn[gc]),
                .genAndSel (st_q.cfg[SL].andGen[ODD]),
                .lutOut    (lutOut[gc]),
                .sumOut    (sumOut[gc]),
                .carryOut  (cellCout[gc])
            );
        end
    endgenerate

    always_comb begin
        logic clkLvl;
        logic prevLvl;
        logic edgeHit;
        logic tick;
        logic ceAct;
        logic initAct;
        logic oppAct;
        logic asyncInit;
        logic asyncOpp;
        logic initBit;
        int   ca;
        int   cb;
        logic [lbs_pkg::LUT_INPUTS-1:0] wa;
        lbs_pkg::lbs_slice_cfg_s cf;
        clkLvl    = 1'b0;
        prevLvl   = 1'b0;
        edgeHit   = 1'b0;
        tick      = 1'b0;
        ceAct     = 1'b0;
        initAct   = 1'b0;
        oppAct    = 1'b0;
        asyncInit = 1'b0;
        asyncOpp  = 1'b0;
        initBit   = 1'b0;
        ca        = 0;
        cb        = 0;
        wa        = '0;
        cf        = lbs_pkg::CFG_RESET;
        st_d      = st_q;
        regOut    = '0;
        cellD     = '0;

        for (int s = 0; s < lbs_pkg::NUM_SLICES; s++) begin
            cf      = st_q.cfg[s];
            ca      = 2 * s;
            cb      = 2 * s + 1;
            wa      = tileIn.lutIn[ca];
            // one inversion per control, shared by both cells of the slice
            clkLvl  = tileIn.sliceClk[s] ^ cf.invClk;              // [RL12]
            prevLvl = st_q.clkPrev[s] ^ cf.invClk;                 // [RL12]
            ceAct   = tileIn.sliceCe[s] ^ cf.invCe;                // [RL12]
            initAct = tileIn.initStateForce[s] ^ cf.invInit;       // [RL12]
            oppAct  = tileIn.oppositeStateForce[s] ^ cf.invOpp;    // [RL12]
            edgeHit = clkLvl & ~prevLvl;
            st_d.clkPrev[s] = tileIn.sliceClk[s];

            // user-logic table writes happen only on the slice's active edge
            if (edgeHit && tileIn.ramWe[s]) begin                  // [RL6]
                case (cf.mode)
                    lbs_pkg::LBS_RAM16X1: begin
                        st_d.truth[ca][wa] = tileIn.ramWd[s][0];                  // [RL3]
                        st_d.truth[cb][tileIn.lutIn[cb]] = tileIn.ramWd[s][1];    // [RL3]
                    end
                    lbs_pkg::LBS_RAM16X2: begin
                        st_d.truth[ca][wa] = tileIn.ramWd[s][0];   // [RL4]
                        st_d.truth[cb][wa] = tileIn.ramWd[s][1];   // [RL4]
                    end
                    lbs_pkg::LBS_RAM32X1: begin
                        // fifth address bit is the combiner select
                        if (tileIn.fiveMuxSel[s]) begin
                            st_d.truth[cb][wa] = tileIn.ramWd[s][0]; // [RL4]
                        end else begin
                            st_d.truth[ca][wa] = tileIn.ramWd[s][0]; // [RL4]
                        end
                    end
                    lbs_pkg::LBS_DPRAM: begin
                        // both copies written, second table reads its own address
                        st_d.truth[ca][wa] = tileIn.ramWd[s][0];   // [RL4]
                        st_d.truth[cb][wa] = tileIn.ramWd[s][0];   // [RL4]
                    end
                    lbs_pkg::LBS_SHIFT: begin
                        st_d.truth[ca] = {st_q.truth[ca][lbs_pkg::LUT_DEPTH-2:0], tileIn.ramWd[s][0]}; // [RL5]
                        st_d.truth[cb] = {st_q.truth[cb][lbs_pkg::LUT_DEPTH-2:0], tileIn.ramWd[s][1]}; // [RL5]
                    end
                    default: begin
                    end
                endcase
            end

            asyncInit = cf.forceAsync & initAct;                   // [RL11]
            asyncOpp  = cf.forceAsync & oppAct & ~initAct;         // [RL11]
            // latch follows its gate level, flip-flop the edge
            tick      = cf.latchMode ? clkLvl : edgeHit;           // [RL7]
            for (int k = 0; k < 2; k++) begin
                initBit = cf.initVal[k];
                cellD[ca+k] = cf.directSel[k] ? tileIn.directIn[ca+k] : lutOut[ca+k]; // [RL8] [RL2]
                if (asyncInit || (tick && initAct)) begin
                    st_d.stored[ca+k] = initBit;                   // [RL9]
                end else if (asyncOpp || (tick && oppAct)) begin
                    st_d.stored[ca+k] = ~initBit;                  // [RL10]
                end else if (tick && ceAct) begin
                    st_d.stored[ca+k] = cellD[ca+k];               // [RL7]
                end
                // asynchronous force and open latch show through at once
                regOut[ca+k] = (asyncInit || asyncOpp || (cf.latchMode && clkLvl))
                               ? st_d.stored[ca+k] : st_q.stored[ca+k]; // [RL11] [RL7]
            end
        end

        // register access
        apbSetup  = apbReq.psel & ~apbReq.penable;
        apbWrite  = apbReq.psel & apbReq.penable & apbReq.pwrite;
        apbMapped = (apbReq.paddr[1:0] == 2'b00) && (apbReq.paddr <= lbs_pkg::ADDR_STATUS);
        readWord  = '0;
        if (apbReq.paddr < lbs_pkg::ADDR_CFG0) begin
            readWord[lbs_pkg::LUT_DEPTH-1:0] = st_q.truth[apbReq.paddr[3:2]];
        end else if (apbReq.paddr == lbs_pkg::ADDR_CFG0) begin
            readWord[lbs_pkg::CFG_W-1:0] = st_q.cfg[0];
        end else if (apbReq.paddr == lbs_pkg::ADDR_CFG1) begin
            readWord[lbs_pkg::CFG_W-1:0] = st_q.cfg[1];
        end else if (apbReq.paddr == lbs_pkg::ADDR_STATUS) begin
            readWord[lbs_pkg::STATUS_W-1:0] = {cellCout[3], cellCout[1], regOut};
        end
        if (apbSetup) begin
            st_d.rdata = apbMapped ? readWord : 32'h0000_0000;
        end
        // software load wins over a same-cycle table write from user logic
        if (apbWrite && apbMapped) begin
            if (apbReq.paddr < lbs_pkg::ADDR_CFG0) begin
                st_d.truth[apbReq.paddr[3:2]] = apbReq.pwdata[lbs_pkg::LUT_DEPTH-1:0]; // [RL1]
            end else if (apbReq.paddr == lbs_pkg::ADDR_CFG0) begin
                st_d.cfg[0] = lbs_pkg::lbs_slice_cfg_s'(apbReq.pwdata[lbs_pkg::CFG_W-1:0]);
            end else if (apbReq.paddr == lbs_pkg::ADDR_CFG1) begin
                st_d.cfg[1] = lbs_pkg::lbs_slice_cfg_s'(apbReq.pwdata[lbs_pkg::CFG_W-1:0]);
            end
        end

        // combiners
        for (int s = 0; s < lbs_pkg::NUM_SLICES; s++) begin
            fiveMux[s] = tileIn.fiveMuxSel[s] ? lutOut[2*s+1] : lutOut[2*s]; // [RL13]
        end
        sixMux = tileIn.sixMuxSel ? fiveMux[1] : fiveMux[0];      // [RL14]

        // wired bus: any enabled driver at zero pulls low, else high
        busNet = 1'b1;                                             // [RL18]
        for (int i = 0; i < 2; i++) begin
            if (!tileIn.busDrvEn_n[i] && !tileIn.busDrvData[i]) begin
                busNet = 1'b0;                                     // [RL19]
            end
        end
        for (int i = 0; i < EXT_DRIVERS; i++) begin
            if (!extDrvEn_n[i] && !extDrvData[i]) begin
                busNet = 1'b0;                                     // [RL19]
            end
        end

        apbRsp.prdata      = st_q.rdata;
        apbRsp.pready      = 1'b1;
        apbRsp.pslverr     = apbReq.psel & apbReq.penable & ~apbMapped;

        tileOut.lutOut     = lutOut;                               // [RL2]
        tileOut.regOut     = regOut;
        tileOut.sumOut     = sumOut;
        tileOut.carryOut   = {cellCout[3], cellCout[1]};           // [RL15]
        tileOut.fiveMux    = fiveMux;
        tileOut.sixMux     = sixMux;
        tileOut.feedOut    = tileIn.feedIn;                        // [RL20]
        tileOut.busDrvOut  = tileIn.busDrvData;                    // [RL17]
        tileOut.busDrvOe_n = tileIn.busDrvEn_n;                    // [RL17]
        tileOut.busNet     = busNet;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q.truth   <= {lbs_pkg::NUM_CELLS{lbs_pkg::TRUTH_RESET}};
            st_q.cfg     <= {lbs_pkg::NUM_SLICES{lbs_pkg::CFG_RESET}};
            st_q.stored  <= '0;
            st_q.clkPrev <= '0;
            st_q.rdata   <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end
endmodule : lbs_logic_tile
`default_nettype wire

// ==== tb/lbs_user_model.sv ====
// Purpose: outside drivers sharing the tile bus net
// Assumes: commands change just after a rising edge
// Notes:   a released line toggles so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module lbs_user_model #(
    parameter int N = 2
) (
    input  wire logic         clock,
    input  wire logic [N-1:0] drvOn,
    input  wire logic [N-1:0] drvVal,
    output var  logic [N-1:0] extDrvData,
    output var  logic [N-1:0] extDrvEn_n
);
    initial extDrvEn_n = '1;
    initial extDrvData = '0;
    always @(posedge clock) begin
        extDrvEn_n <= ~drvOn;
        for (int i = 0; i < N; i++) begin
            extDrvData[i] <= drvOn[i] ? drvVal[i] : ~extDrvData[i];
        end
    end
endmodule : lbs_user_model
`default_nettype wire

// ==== tb/lbs_logic_tile_checker.sv ====
// Purpose: port-level assertions for the logic tile
// Assumes: one clock, synchronous active-high reset
// Notes:   combiner polarity checked only where both inputs agree
`timescale 1ns/100ps
`default_nettype none
module lbs_logic_tile_checker #(
    parameter int EXT_DRIVERS = 2
) (
    input wire logic                   clock,
    input wire logic                   sys_rst,
    input wire logic                   clkEn,
    input wire lbs_pkg::lbs_apb_req_s  apbReq,
    input wire lbs_pkg::lbs_apb_rsp_s  apbRsp,
    input wire lbs_pkg::lbs_tile_in_s  tileIn,
    input wire logic [EXT_DRIVERS-1:0] extDrvData,
    input wire logic [EXT_DRIVERS-1:0] extDrvEn_n,
    input wire lbs_pkg::lbs_tile_out_s tileOut
);
    logic busLow;
    assign busLow = |(~tileIn.busDrvEn_n & ~tileIn.busDrvData) | |(~extDrvEn_n & ~extDrvData);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_low; busLow |-> !tileOut.busNet; endproperty
    a_low: assert property (p_low) else $error("bus net not low on conflict");
    property p_high; !busLow |-> tileOut.busNet; endproperty
    a_high: assert property (p_high) else $error("bus net not high");
    property p_drv; tileOut.busDrvOe_n == tileIn.busDrvEn_n && tileOut.busDrvOut == tileIn.busDrvData; endproperty
    a_drv: assert property (p_drv) else $error("bus driver mismatch");
    property p_feed; tileOut.feedOut == tileIn.feedIn; endproperty
    a_feed: assert property (p_feed) else $error("feedthrough mismatch");
    property p_sum; tileOut.sumOut[0] == (tileOut.lutOut[0] ^ tileIn.carryIn[0]); endproperty
    a_sum: assert property (p_sum) else $error("sum mismatch");
    property p_carry; &tileOut.lutOut[1:0] |-> tileOut.carryOut[0] == tileIn.carryIn[0]; endproperty
    a_carry: assert property (p_carry) else $error("carry not propagated");
    property p_five; tileOut.lutOut[2] == tileOut.lutOut[3] |-> tileOut.fiveMux[1] == tileOut.lutOut[2]; endproperty
    a_five: assert property (p_five) else $error("five combiner mismatch");
    property p_six; tileOut.fiveMux[0] == tileOut.fiveMux[1] |-> tileOut.sixMux == tileOut.fiveMux[0]; endproperty
    a_six: assert property (p_six) else $error("six combiner mismatch");
    sequence s_bad; apbReq.psel && !apbReq.penable && apbReq.paddr > 8'h18 ##1 apbReq.penable; endsequence
    property p_err; s_bad |-> apbRsp.pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped access");
    property p_stat;
        apbReq.psel && !apbReq.penable && apbReq.paddr == lbs_pkg::ADDR_STATUS && clkEn
        |=> apbRsp.prdata[3:0] == $past(tileOut.regOut);
    endproperty
    a_stat: assert property (p_stat) else $error("status does not mirror storage");
    property p_rst; disable iff (1'b0) sys_rst |=> tileOut.regOut == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("storage not cleared by reset");
    c_conf: cover property (busLow && |(~tileIn.busDrvEn_n & tileIn.busDrvData));
    c_err: cover property (apbRsp.pslverr);
    c_six: cover property (tileOut.sixMux && tileIn.sixMuxSel);
endmodule : lbs_logic_tile_checker
bind lbs_logic_tile lbs_logic_tile_checker #(.EXT_DRIVERS(EXT_DRIVERS)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
    .tileIn(tileIn), .extDrvData(extDrvData), .extDrvEn_n(extDrvEn_n), .tileOut(tileOut));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the logic tile
// Assumes: select 0 of a combiner picks the even input
// Notes:   slice clock pulses last one system cycle, two in the latch test
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                   clock = 1'b0;
    logic                   sysRst = 1'b1;
    logic                   clkEn = 1'b1;
    lbs_pkg::lbs_apb_req_s  req = '0;
    lbs_pkg::lbs_apb_rsp_s  rsp;
    lbs_pkg::lbs_tile_in_s  tIn = '0;
    lbs_pkg::lbs_tile_out_s tOut;
    logic [1:0]             extD;
    logic [1:0]             extEn_n;
    logic [1:0]             drvOn = 2'h0;
    logic [1:0]             drvVal = 2'h0;
    logic [31:0]            rd;
    logic                   err;
    logic [3:0]             l;
    logic [5:0]             v;
    logic                   c0;
    logic                   f0;
    logic                   f1;
    int                     errorCnt = 0;
    int                     testsRun = 0;
    logic [15:0]            pat [4] = '{16'h6996, 16'h8001, 16'hf00f, 16'h1234};
    logic [15:0]            e0 [5] = '{16'h0020, 16'h0020, 16'h0000, 16'h0020, 16'h0001};
    logic [15:0]            e1 [5] = '{16'h0200, 16'h0020, 16'h0020, 16'h0020, 16'h0001};
    logic [4:0]             e5 = 5'b00111;

    lbs_logic_tile #(.EXT_DRIVERS(2)) u_dut (.clock(clock), .sys_rst(sysRst), .clkEn(clkEn),
        .apbReq(req), .apbRsp(rsp), .tileIn(tIn), .extDrvData(extD), .extDrvEn_n(extEn_n), .tileOut(tOut));
    lbs_user_model #(.N(2)) u_usr (.clock(clock), .drvOn(drvOn), .drvVal(drvVal),
        .extDrvData(extD), .extDrvEn_n(extEn_n));

    initial forever #12.5 clock = ~clock;

    task automatic completeRun();
        $display("errors=%0d checks=%0d", errorCnt, testsRun);
        if (errorCnt == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : completeRun

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            errorCnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic chkF(input logic [3:0] g, input logic [3:0] e);
        chk({28'h0, g}, {28'h0, e});
    endtask : chkF

    // no fixed latency assumed: wait for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        do @(posedge clock); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rc

    // low level held a cycle after, so the next pulse is a fresh edge
    task automatic sclk(input int s);
        @(posedge clock);
        tIn.sliceClk[s] <= 1'b1;
        @(posedge clock);
        tIn.sliceClk[s] <= 1'b0;
        @(posedge clock);
    endtask : sclk

    task automatic st(input logic ce, fi, fo, input logic [1:0] dn, input logic [3:0] e);
        @(posedge clock);
        tIn.sliceCe[1] <= ce;
        tIn.initStateForce[1] <= fi;
        tIn.oppositeStateForce[1] <= fo;
        tIn.directIn[3:2] <= dn;
        sclk(1);
        @(negedge clock);
        chkF(tOut.regOut, e);
    endtask : st

    initial begin
        #200000;
        errorCnt++;
        completeRun();
    end

    initial begin
        repeat (12) @(posedge clock);
        sysRst <= 1'b0;
        for (int a = 0; a <= 24; a += 4) rc(8'(a), 32'h0);
        rc(8'h1c, 32'h0);
        chkF({3'b0, err}, 4'h1);
        rc(8'h02, 32'h0);
        chkF({3'b0, err}, 4'h1);
        apb(1'b1, 8'h00, 32'hffffffff);
        rc(8'h00, 32'h0000ffff);
        apb(1'b1, 8'h18, 32'hffffffff);
        rc(8'h18, 32'h0);
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h10, 32'(m + 1));
            @(posedge clock);
            tIn.lutIn[0] <= 4'h5;
            tIn.lutIn[1] <= 4'h9;
            tIn.fiveMuxSel[0] <= 1'b1;
            tIn.ramWe[0] <= 1'b1;
            tIn.ramWd[0] <= 2'b11;
            sclk(0);
            tIn.ramWe[0] <= 1'b0;
            @(negedge clock);
            chkF({3'b0, tOut.fiveMux[0]}, {3'b0, e5[m]});
            rc(8'h00, 32'(e0[m]));
            rc(8'h04, 32'(e1[m]));
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h10, 32'h1);
        sclk(0);
        rc(8'h00, 32'h0);
        apb(1'b1, 8'h10, 32'h0);
        for (int c = 0; c < 4; c++) apb(1'b1, 8'(c * 4), 32'(pat[c]));
        for (int a = 0; a < 16; a++) begin
            @(posedge clock);
            tIn.lutIn <= {4{4'(a)}};
            tIn.fiveMuxSel <= 2'(a);
            tIn.sixMuxSel <= a[2];
            tIn.carryIn <= 2'(a >> 2);
            tIn.directIn <= ~4'(a);
            tIn.feedIn <= 4'(a);
            for (int c = 0; c < 4; c++) l[c] = pat[c][a];
            f0 = a[0] ? l[1] : l[0];
            f1 = a[1] ? l[3] : l[2];
            c0 = l[0] ? a[2] : ~a[0];
            @(negedge clock);
            chkF(tOut.lutOut, l);
            chkF({tOut.fiveMux, tOut.sixMux, 1'b0}, {f1, f0, a[2] ? f1 : f0, 1'b0});
            chkF({tOut.sumOut[1], tOut.carryOut[0], 2'b0}, {l[1] ^ c0, l[1] ? c0 : ~a[1], 2'b0});
            chkF(tOut.feedOut, 4'(a));
        end
        @(posedge clock);
        clkEn <= 1'b0;
        apb(1'b1, 8'h00, 32'h0);
        clkEn <= 1'b1;
        rc(8'h00, 32'h6996);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h10, 32'h6000);
        @(posedge clock);
        tIn.lutIn <= {4{4'h3}};
        tIn.directIn <= 4'h0;
        @(negedge clock);
        chkF({tOut.carryOut[0], 3'b0}, 4'b1000);
        apb(1'b1, 8'h14, 32'h0e0);
        st(1'b1, 1'b0, 1'b0, 2'b01, 4'b0100);
        st(1'b0, 1'b0, 1'b0, 2'b10, 4'b0100);
        st(1'b1, 1'b1, 1'b0, 2'b10, 4'b1000);
        st(1'b1, 1'b0, 1'b1, 2'b10, 4'b0100);
        st(1'b1, 1'b1, 1'b1, 2'b01, 4'b1000);
        apb(1'b1, 8'h14, 32'h460);
        st(1'b0, 1'b0, 1'b0, 2'b11, 4'b0100);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd & 32'hf, 32'h4);
        apb(1'b1, 8'h14, 32'h0e8);
        @(posedge clock);
        tIn.sliceCe[1] <= 1'b1;
        tIn.sliceClk[1] <= 1'b1;
        @(posedge clock);
        tIn.directIn[3:2] <= 2'b00;
        @(negedge clock);
        chkF(tOut.regOut, 4'b0000);
        @(posedge clock);
        tIn.sliceClk[1] <= 1'b0;
        repeat (2) @(posedge clock);
        tIn.directIn[3:2] <= 2'b11;
        @(negedge clock);
        chkF(tOut.regOut, 4'b0000);
        apb(1'b1, 8'h14, 32'h11e0);
        @(negedge clock);
        chkF(tOut.regOut, 4'b0100);
        apb(1'b1, 8'h14, 32'h19e0);
        @(negedge clock);
        chkF(tOut.regOut, 4'b1000);
        for (int i = 0; i < 64; i++) begin
            v = 6'(i);
            @(posedge clock);
            tIn.busDrvEn_n <= v[1:0];
            tIn.busDrvData <= v[3:2];
            drvOn <= v[5:4];
            drvVal <= ~v[3:2];
            repeat (2) @(posedge clock);
            c0 = |(~v[1:0] & ~v[3:2]) | |(v[5:4] & v[3:2]);
            @(negedge clock);
            chkF({tOut.busNet, 1'b0, tOut.busDrvOe_n}, {~c0, 1'b0, v[1:0]});
        end
        completeRun();
    end
endmodule : tb_top
`default_nettype wire
